/* File: hdl/hioc_defs.vh */
// register offsets, field positions, reset values and timing for the host interrupt output controller
`ifndef HIOC_DEFS_VH
`define HIOC_DEFS_VH
`define HIOC_ADDR_W 8
`define HIOC_OFS_IDREV 8'h50
`define HIOC_OFS_CFG 8'h54
`define HIOC_OFS_STS 8'h58
`define HIOC_OFS_EN 8'h5c
`define HIOC_OFS_BTEST 8'h64
`define HIOC_BTEST_VAL 32'h87654321
`define HIOC_CFG_RST 32'h00000000
`define HIOC_STS_RST 32'h00000000
`define HIOC_EN_RST 32'h00000000
`define HIOC_INTV_HI 31
`define HIOC_INTV_LO 24
`define HIOC_RESTART_BIT 14
`define HIOC_ACTIVE_BIT 13
`define HIOC_MASTER_BIT 12
`define HIOC_OUTEN_BIT 8
`define HIOC_POL_BIT 4
`define HIOC_TYPE_BIT 0
`define HIOC_PWR_EVT_BIT 17
`define HIOC_STS_MASK 32'h82ffe7ff
`define HIOC_TICK_NS 10000
`define HIOC_CLK_NS 100
`define HIOC_TICK_CYCLES (`HIOC_TICK_NS / `HIOC_CLK_NS)
`endif

/* File: hdl/hioc_tick_gen.v */
// ten microsecond tick generator for the hold-off counter
`timescale 1ns/1ps
`default_nettype none
module hioc_tick_gen #(
    parameter TICK_CYCLES = 100
) (
    input wire sys_clk,
    input wire rst,
    input wire restart,
    output reg tick
);
    reg [15:0] count;
    always @(posedge sys_clk)
    begin
        if (rst || restart)
        begin
            count <= 16'h0000;
            tick <= 1'b0;
        end
        else if (count == TICK_CYCLES[15:0] - 16'h0001)
        begin
            count <= 16'h0000;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule // hioc_tick_gen
`default_nettype wire

/* File: hdl/hioc_pin_drv.v */
// interrupt pin driver: polarity and open-drain or push-pull shaping
`timescale 1ns/1ps
`default_nettype none
module hioc_pin_drv (
    input wire sys_clk,
    input wire rst,
    input wire assert_pin,
    input wire pin_polarity,
    input wire push_pull,
    output reg irq_o,
    output reg irq_oe
);
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            irq_o <= 1'b0;
            irq_oe <= 1'b0;
        end
        else if (push_pull)
        begin
            irq_o <= assert_pin ~^ pin_polarity;
            irq_oe <= 1'b1;
        end
        else
        begin
            irq_o <= 1'b0;
            irq_oe <= assert_pin;
        end
    end
endmodule // hioc_pin_drv
`default_nettype wire

/* File: hdl/hioc_top.v */
// host interrupt output controller with its register map slice
// Operation
// - interval field in config bits 31:24 gives hold-off in ten microsecond steps.
// - writing zero interval disables hold-off, clears counter, releases pending interrupts.
// - a new non-zero interval applies to all interrupts except the power event after the write.
// - the power event interrupt is never delayed by hold-off.
// - writing one to restart bit reloads counter and starts a fresh interval.
// - holdoff_active bit reads one while interrupts are withheld from the pin.
// - master bit mirrors OR of enabled interrupts, ignoring enable and hold-off.
// - output enable clear keeps pin deasserted; status bits untouched.
// - polarity bit selects active high or low; open-drain always active low.
// - buffer-type bit zero gives open-drain, one gives push-pull.
// - polarity and buffer type survive soft reset; only hard reset restores them.
// - identity register is read-only: design code high, revision low.
// - byte-order test register always reads the fixed pattern.
// - registers decode at fixed offsets; unmapped offsets read zero.
// - writing one clears a status bit; writing zero leaves it.
`timescale 1ns/1ps
`default_nettype none
`include "hioc_defs.vh"
module hioc_top #(
    parameter [15:0] DESIGN_ID = 16'h0a5c, // arbitrary value
    parameter [15:0] REVISION = 16'h0000,
    parameter TICK_CYCLES = `HIOC_TICK_CYCLES
) (
    input wire sys_clk,
    input wire rst,
    input wire soft_rst,
    input wire [7:0] addr,
    input wire cs,
    input wire wr,
    input wire rd,
    input wire [31:0] wdata,
    output reg [31:0] rdata,
    input wire [31:0] event_set,
    output wire irq_o,
    output wire irq_oe
);
    reg [7:0] holdoff_interval;
    reg [7:0] holdoff_count;
    reg holdoff_active;
    reg out_enable;
    reg pin_polarity;
    reg push_pull;
    reg [31:0] interrupt_status;
    reg [31:0] interrupt_enable_mask;
    reg master_q;
    reg pin_on;
    reg [31:0] next_rdata;
    reg next_holdoff_active;
    reg [7:0] next_holdoff_count;
    wire any_rst;
    wire wr_cfg;
    wire wr_sts;
    wire wr_en;
    wire restart;
    wire tick;
    wire [31:0] active_bits;
    wire master;
    wire pwr_evt_on;
    wire other_on;
    wire assert_pin;
    wire [31:0] next_status;
    wire [31:0] cfg_read;
    wire clear_write;
    wire pin_drop;
    wire count_done;
    wire withheld_on;
    wire [7:0] written_interval;
    wire rd_req;
    genvar gi;

    localparam [31:0] CFG_RST = `HIOC_CFG_RST;
    localparam [31:0] STS_MASK = `HIOC_STS_MASK;
    localparam [31:0] PWR_EVT_MASK = 32'h00000001 << `HIOC_PWR_EVT_BIT;
    localparam HOLD_IDLE = 1'b0;
    localparam HOLD_RUN = 1'b1;

    assign any_rst = rst | soft_rst;
    assign wr_cfg = cs & wr & (addr == `HIOC_OFS_CFG);
    assign wr_sts = cs & wr & (addr == `HIOC_OFS_STS);
    assign wr_en = cs & wr & (addr == `HIOC_OFS_EN);
    assign restart = wr_cfg & wdata[`HIOC_RESTART_BIT];
    assign written_interval = wdata[`HIOC_INTV_HI:`HIOC_INTV_LO];
    assign clear_write = wr_cfg & (written_interval == 8'h00);
    assign pin_drop = pin_on & ~assert_pin;
    assign count_done = (holdoff_count <= 8'h01);
    assign rd_req = cs & rd;

    // status bits: set wins over a same-cycle clear; reserved bits stay zero
    generate
        for (gi = 0; gi < 32; gi = gi + 1)
        begin : g_sts
            assign next_status[gi] = STS_MASK[gi]
                                     & (event_set[gi] | (interrupt_status[gi] & ~(wr_sts & wdata[gi])));
        end
    endgenerate

    always @(posedge sys_clk)
    begin
        if (any_rst)
        begin
            interrupt_status <= `HIOC_STS_RST;
        end
        else
        begin
            interrupt_status <= next_status;
        end
    end

    always @(posedge sys_clk)
    begin
        if (any_rst)
        begin
            interrupt_enable_mask <= `HIOC_EN_RST;
        end
        else if (wr_en)
        begin
            interrupt_enable_mask <= wdata;
        end
    end

    assign active_bits = interrupt_status & interrupt_enable_mask;
    assign master = |active_bits;
    assign pwr_evt_on = active_bits[`HIOC_PWR_EVT_BIT];
    assign other_on = |(active_bits & ~PWR_EVT_MASK);

    always @(posedge sys_clk)
    begin
        if (any_rst)
            master_q <= 1'b0;
        else
            master_q <= master;
    end

    // configuration fields cleared by any reset
    always @(posedge sys_clk)
    begin
        if (any_rst)
        begin
            holdoff_interval <= CFG_RST[`HIOC_INTV_HI:`HIOC_INTV_LO];
            out_enable <= 1'b0;
        end
        else if (wr_cfg)
        begin
            holdoff_interval <= wdata[`HIOC_INTV_HI:`HIOC_INTV_LO];
            out_enable <= wdata[`HIOC_OUTEN_BIT];
        end
    end

    // pin shaping bits survive soft reset
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            pin_polarity <= 1'b0;
            push_pull <= 1'b0;
        end
        else if (wr_cfg)
        begin
            pin_polarity <= wdata[`HIOC_POL_BIT];
            push_pull <= wdata[`HIOC_TYPE_BIT];
        end
    end

    hioc_tick_gen #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .sys_clk(sys_clk),
        .rst(any_rst),
        .restart(restart | pin_drop),
        .tick(tick)
    );

    // hold-off state: starts on pin deassertion or restart, counts down in ticks
    always @*
    begin
        next_holdoff_active = holdoff_active;
        next_holdoff_count = holdoff_count;
        if (clear_write)
        begin
            next_holdoff_active = HOLD_IDLE;
            next_holdoff_count = 8'h00;
        end
        else if (restart)
        begin
            next_holdoff_active = HOLD_RUN;
            next_holdoff_count = written_interval;
        end
        else if (pin_drop && holdoff_interval != 8'h00)
        begin
            next_holdoff_active = HOLD_RUN;
            next_holdoff_count = holdoff_interval;
        end
        else
        begin
            case (holdoff_active)
                HOLD_RUN:
                begin
                    if (tick && count_done)
                    begin
                        next_holdoff_active = HOLD_IDLE;
                        next_holdoff_count = 8'h00;
                    end
                    else if (tick)
                        next_holdoff_count = holdoff_count - 8'h01;
                end
                default:
                begin
                    next_holdoff_active = HOLD_IDLE;
                    next_holdoff_count = holdoff_count;
                end
            endcase
        end
    end

    always @(posedge sys_clk)
    begin
        if (any_rst)
        begin
            holdoff_active <= HOLD_IDLE;
            holdoff_count <= 8'h00;
        end
        else
        begin
            holdoff_active <= next_holdoff_active;
            holdoff_count <= next_holdoff_count;
        end
    end

    // power event bypasses the hold-off window
    assign withheld_on = other_on & ~holdoff_active;
    assign assert_pin = out_enable & (withheld_on | pwr_evt_on);

    always @(posedge sys_clk)
    begin
        if (any_rst)
            pin_on <= 1'b0;
        else
            pin_on <= assert_pin;
    end

    hioc_pin_drv u_pin (
        .sys_clk(sys_clk),
        .rst(rst),
        .assert_pin(assert_pin),
        .pin_polarity(pin_polarity),
        .push_pull(push_pull),
        .irq_o(irq_o),
        .irq_oe(irq_oe)
    );

    // config readback; restart bit self-clears and reserved bits read zero
    assign cfg_read = {
        holdoff_interval,
        9'h000,
        1'b0,
        holdoff_active,
        master_q,
        3'h0,
        out_enable,
        3'h0,
        pin_polarity,
        3'h0,
        push_pull
    };

    always @*
    begin
        case (addr)
            `HIOC_OFS_IDREV:
            begin
                next_rdata = {DESIGN_ID, REVISION};
            end
            `HIOC_OFS_CFG:
            begin
                next_rdata = cfg_read;
            end
            `HIOC_OFS_STS:
            begin
                next_rdata = interrupt_status;
            end
            `HIOC_OFS_EN:
            begin
                next_rdata = interrupt_enable_mask;
            end
            `HIOC_OFS_BTEST:
            begin
                next_rdata = `HIOC_BTEST_VAL;
            end
            default:
            begin
                next_rdata = 32'h00000000;
            end
        endcase
    end

    always @(posedge sys_clk)
    begin
        if (rst)
            rdata <= 32'h00000000;
        else if (rd_req)
            rdata <= next_rdata;
    end
endmodule // hioc_top
`default_nettype wire

/* File: tb/hioc_asserts.sv */
// port checker for the host interrupt output controller
`timescale 1ns/1ps
`default_nettype none
module hioc_asserts #(
    parameter [15:0] DESIGN_ID = 16'h0a5c,
    parameter [15:0] REVISION = 16'h0000
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic soft_rst,
    input wire logic [7:0] addr,
    input wire logic cs,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic [31:0] event_set,
    input wire logic irq_o,
    input wire logic irq_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire logic rq = cs && rd;
    wire logic wq = cs && wr;
    btest_read_a:
    assert property (rq && addr == 8'h64 |=> rdata == 32'h87654321) else $error("byte test value wrong");
    id_read_a:
    assert property (rq && addr == 8'h50 |=> rdata == {DESIGN_ID, REVISION}) else $error("identity value wrong");
    unmapped_zero_a:
    assert property (rq && (addr == 8'h60 || addr >= 8'hb8) |=> rdata == 32'h0) else $error("unmapped read not zero");
    rdata_hold_a:
    assert property (!rq |=> $stable(rdata)) else $error("read data moved without a read");
    sts_mask_a:
    assert property (rq && addr == 8'h58 |=> (rdata & ~32'h82ffe7ff) == 32'h0) else $error("status reserved bit set");
    drive_type_a:
    assert property (irq_o |-> irq_oe) else $error("pin high while not driven");
    en_back_a:
    assert property (wq && addr == 8'h5c ##2 rq && addr == 8'h5c |=> rdata == $past(wdata, 3))
        else $error("enable readback wrong");
    sts_clear_a:
    assert property ((wq && addr == 8'h58 && event_set == 0) ##1 event_set == 0 ##1 (rq && addr == 8'h58
        && event_set == 0) |=> (rdata & $past(wdata, 3)) == 32'h0) else $error("status bit not cleared");
    cfg_back_a:
    assert property (wq && addr == 8'h54 ##2 rq && addr == 8'h54 |=>
        (rdata & 32'hff000111) == ($past(wdata, 3) & 32'hff000111)) else $error("config readback wrong");
endmodule // hioc_asserts
bind hioc_top hioc_asserts #(.DESIGN_ID(DESIGN_ID), .REVISION(REVISION)) chk_u (.sys_clk(sys_clk), .rst(rst),
    .soft_rst(soft_rst), .addr(addr), .cs(cs), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata),
    .event_set(event_set), .irq_o(irq_o), .irq_oe(irq_oe));
`default_nettype wire

/* File: tb/hioc_host_model.sv */
// host side of the interrupt wire: pull-up plus the device driver
`timescale 1ns/1ps
`default_nettype none
module hioc_host_model (
    input wire logic irq_o,
    input wire logic irq_oe,
    output wire logic irq_line
);
    // undriven wire floats to the pull-up level, allowing wired-or sharing
    assign irq_line = irq_oe ? irq_o : 1'b1;
endmodule // hioc_host_model
`default_nettype wire

/* File: tb/host_interrupt_output_control_bench.sv */
// register and pin tests for the host interrupt output controller
`timescale 1ns/1ps
`default_nettype none
module host_interrupt_output_control_bench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic soft_rst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic cs = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] event_set = 32'h0;
    wire logic [31:0] rdata;
    wire logic irq_o;
    wire logic irq_oe;
    wire logic irq_line;
    int n_errors = 0;
    int total_checks = 0;
    hioc_top #(.TICK_CYCLES(4)) dut_u (.sys_clk(sys_clk), .rst(rst), .soft_rst(soft_rst), .addr(addr), .cs(cs),
        .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata), .event_set(event_set), .irq_o(irq_o), .irq_oe(irq_oe));
    hioc_host_model host_u (.irq_o(irq_o), .irq_oe(irq_oe), .irq_line(irq_line));
    initial
    begin
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        cs <= 1'b1;
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        cs <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge sys_clk);
        cs <= 1'b1;
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        cs <= 1'b0;
        rd <= 1'b0;
        @(negedge sys_clk);
        chk(rdata & m, e);
    endtask
    task automatic ev(input logic [31:0] b);
        @(posedge sys_clk);
        event_set <= b;
        @(posedge sys_clk);
        event_set <= 32'h0;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic pin(input logic e);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({31'h0, irq_line}, {31'h0, e});
    endtask
    task automatic final_report;
        if (n_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        final_report;
    end
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        wr_reg(8'h50, 32'hffffffff);
        wr_reg(8'h64, 32'h0);
        rd_chk(8'h50, 32'hffffffff, {16'h0a5c, 16'h0000});
        rd_chk(8'h64, 32'hffffffff, 32'h87654321);
        rd_chk(8'h54, 32'hffffffff, 32'h0);
        rd_chk(8'h58, 32'hffffffff, 32'h0);
        rd_chk(8'h5c, 32'hffffffff, 32'h0);
        rd_chk(8'h60, 32'hffffffff, 32'h0);
        rd_chk(8'hc0, 32'hffffffff, 32'h0);
        wr_reg(8'h5c, 32'h00020001);
        rd_chk(8'h5c, 32'hffffffff, 32'h00020001);
        wr_reg(8'h54, 32'h00000111);
        ev(32'h1);
        pin(1'b1);
        rd_chk(8'h54, 32'h00001000, 32'h00001000);
        wr_reg(8'h58, 32'h1);
        rd_chk(8'h58, 32'h00000001, 32'h0);
        pin(1'b0);
        wr_reg(8'h54, 32'h00000101);
        ev(32'h1);
        pin(1'b0);
        wr_reg(8'h58, 32'h1);
        pin(1'b1);
        wr_reg(8'h54, 32'h00000110);
        ev(32'h1);
        pin(1'b0);
        wr_reg(8'h58, 32'h1);
        pin(1'b1);
        wr_reg(8'h54, 32'h00000011);
        ev(32'h1);
        pin(1'b0);
        rd_chk(8'h58, 32'h00000001, 32'h00000001);
        rd_chk(8'h54, 32'h00001000, 32'h00001000);
        wr_reg(8'h58, 32'h1);
        // sixteen ticks of four cycles each
        wr_reg(8'h54, 32'h10000111);
        rd_chk(8'h54, 32'hff000111, 32'h10000111);
        ev(32'h1);
        pin(1'b1);
        wr_reg(8'h58, 32'h1);
        ev(32'h1);
        pin(1'b0);
        rd_chk(8'h54, 32'h00002000, 32'h00002000);
        repeat (48) @(posedge sys_clk);
        pin(1'b0);
        repeat (4) @(posedge sys_clk);
        pin(1'b1);
        wr_reg(8'h58, 32'h1);
        ev(32'h1);
        repeat (42) @(posedge sys_clk);
        wr_reg(8'h54, 32'h10004111);
        repeat (30) @(posedge sys_clk);
        pin(1'b0);
        ev(32'h00020000);
        pin(1'b1);
        wr_reg(8'h58, 32'h00020000);
        pin(1'b0);
        wr_reg(8'h54, 32'h00000111);
        pin(1'b1);
        rd_chk(8'h54, 32'h00003000, 32'h00001000);
        wr_reg(8'h58, 32'h1);
        @(posedge sys_clk);
        soft_rst <= 1'b1;
        @(posedge sys_clk);
        soft_rst <= 1'b0;
        rd_chk(8'h54, 32'hffffffff, 32'h00000011);
        rd_chk(8'h5c, 32'hffffffff, 32'h0);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(8'h54, 32'hffffffff, 32'h0);
        pin(1'b1);
        final_report;
    end
endmodule // host_interrupt_output_control_bench
`default_nettype wire
